// ### common/xcvr_cfg_pkg.sv
// constants shared by the transceiver configuration register bank and its timers
// assumes a single 250 MHz clock that doubles as the master clock
package xcvr_cfg_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_TIMER_RESTART = 8'h0c;
  localparam logic [7:0] OFF_TIMER_ENABLE = 8'h0d;
  localparam logic [7:0] OFF_TIMER_CONTINUOUS = 8'h0e;
  localparam logic [7:0] OFF_MISC_MODE_CONTROL = 8'h0f;
  localparam logic [7:0] OFF_STARTUP_INTERVAL_ONE = 8'h10;
  localparam logic [7:0] OFF_STARTUP_INTERVAL_TWO = 8'h12;
  localparam logic [7:0] OFF_STARTUP_INTERVAL_THREE = 8'h14;
  localparam logic [7:0] OFF_STARTUP_INTERVAL_FOUR = 8'h16;
  localparam logic [7:0] OFF_METER_INTERVAL = 8'h18;
  localparam logic [7:0] OFF_NOISE_ALARM_INTERVAL = 8'h1a;
  localparam logic [7:0] OFF_GENERAL_INTERVAL_THREE = 8'h1c;
  localparam logic [7:0] OFF_GENERAL_INTERVAL_FOUR = 8'h1e;
  localparam logic [7:0] OFF_RATE_SELECT_LOW = 8'h20;
  localparam logic [7:0] OFF_RECEIVE_CONVERTER_CONTROL = 8'h21;
  localparam logic [7:0] OFF_LOOP_MODES = 8'h22;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MISC_ASYNC_MODE_BIT = 0;
  localparam int MISC_REGEN_CLOCK_BIT = 5;
  localparam int RCC_FILTER_LSB = 6;
  localparam int RCC_LOOPBACK_LSB = 4;
  localparam int RCC_PULSE_POLE_BIT = 3;
  localparam int RCC_GAIN_LSB = 0;
  localparam int LOOP_MODES_RATE_HIGH_LSB = 6;
  localparam int NUM_TIMERS = 8;
  localparam int NUM_STARTUP_TIMERS = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_MISC_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_RATE_SELECT_LOW = 8'h00;
  localparam logic [7:0] RST_RECEIVE_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] RST_LOOP_MODES = 8'h00;
  localparam logic [7:0] RST_TIMER_BITS = 8'h00;
  localparam logic [15:0] RST_INTERVAL = 16'h0000;

  // ----------------------------------------
  // rate and loopback codes
  // ----------------------------------------
  localparam logic [9:0] RATE_CODE_UNPROGRAMMED = 10'h000;
  localparam logic [9:0] RATE_CODE_DEFAULT = 10'h0a0;
  localparam logic [1:0] LOOPBACK_NORMAL = 2'h0;
  localparam logic [1:0] LOOPBACK_NO_BALANCE = 2'h1;
  localparam logic [1:0] LOOPBACK_TRANSMITTING = 2'h2;
  localparam logic [1:0] LOOPBACK_SILENT = 2'h3;

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam int MCLK_PER_SYMBOL = 16;
  localparam int SYMBOLS_PER_STARTUP_STEP = 1024;
  localparam logic [3:0] SYMBOL_DIV_LAST = 4'(MCLK_PER_SYMBOL - 1);
  localparam logic [9:0] STARTUP_DIV_LAST = 10'(SYMBOLS_PER_STARTUP_STEP - 1);

endpackage

// ### hdl/countdown_timer.sv
// one 16-bit countdown timer, advanced once per tick
// assumes tick is a single-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module countdown_timer
  import xcvr_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [15:0] interval,
  input wire logic restart,
  input wire logic enable,
  input wire logic continuous,
  output logic reload_ack,
  output logic [15:0] count_r
);

  logic [15:0] count_nxt;
  logic at_zero;

  assign at_zero = (count_r == 16'h0000);
  assign reload_ack = tick & restart;

  always_comb begin
    count_nxt = count_r;
    if (tick) begin
      if (restart) begin
        count_nxt = interval;
      end else if (enable && at_zero && continuous) begin
        count_nxt = interval;
      end else if (enable && !at_zero) begin
        count_nxt = count_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_r <= RST_INTERVAL;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule
`default_nettype wire

// ### hdl/xcvr_cfg_regs.sv
// configuration register bank of a line transceiver behind a byte-wide host interface
// assumes host pins are asynchronous to CLOCK, and CLOCK is also the master clock
//
// Overview of operation
// - misc mode register, reserved bits included, clears to zero on reset.
// - regenerator clock bit bypasses synthesizer; symbol rate is master clock over sixteen.
// - async mode bit selects asynchronous host timing, clear selects synchronous.
// - four startup timers take 16-bit intervals counted in 1024-symbol steps.
// - meter, noise alarm and two general timers count single symbol periods.
// - setting a restart bit loads the interval into that timer's counter.
// - continuous timer reloads its interval after reaching zero.
// - 10-bit rate value sets data rate, low byte here, top bits in loop modes.
// - rate value resets to zero, which means 1280 kbps operation.
// - filter field bits 7:6 pick reconstruction cutoff by data rate range.
// - loopback field bits 5:4 pick normal, no balance, transmitting or silent.
// - transmitting loopback disables main receive inputs, receives via balance inputs.
// - silent loopback turns transmitter off and routes shaping filter into converter.
// - restart reloads within one tick of its timer, then clears itself.
// - pulse pole bit selects 2320 kbps pulse shape when set.
`timescale 1ns/1ps
`default_nettype none
module xcvr_cfg_regs
  import xcvr_cfg_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic HOST_CS_N,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  input wire logic SYNTH_SYMBOL_TICK,
  output logic [9:0] RATE_SELECT,
  output logic SYNTH_BYPASS,
  output logic HOST_ASYNC_TIMING,
  output logic SYMBOL_STROBE,
  output logic [NUM_TIMERS-1:0] TIMER_AT_ZERO,
  output logic [1:0] FILTER_RANGE,
  output logic PULSE_POLE,
  output logic [2:0] VGA_GAIN,
  output logic RX_MAIN_DISABLE,
  output logic BALANCE_DISABLE,
  output logic TX_DISABLE,
  output logic INTERNAL_LOOP
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_interval(input logic [7:0] addr);
    is_interval = (addr[7:4] == OFF_STARTUP_INTERVAL_ONE[7:4]);
  endfunction

  // ----------------------------------------
  // host pin synchronisers
  // ----------------------------------------
  logic [18:0] pin_meta_r;
  logic [18:0] pin_sync_r;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_meta_r <= 19'h70000;
      pin_sync_r <= 19'h70000;
    end else begin
      pin_meta_r <= {HOST_CS_N, HOST_RD_N, HOST_WR_N, HOST_ADDR, HOST_DATA_IN};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [7:0] addr_s;
  logic [7:0] wdata_s;

  assign cs_n_s = pin_sync_r[18];
  assign rd_n_s = pin_sync_r[17];
  assign wr_n_s = pin_sync_r[16];
  assign addr_s = pin_sync_r[15:8];
  assign wdata_s = pin_sync_r[7:0];

  // ----------------------------------------
  // write strobe timing
  // ----------------------------------------
  logic misc_mode_r;
  logic [7:0] misc_r;
  logic wr_act;
  logic rd_act;
  logic wr_act_d_r;
  logic [7:0] hold_addr_r;
  logic [7:0] hold_data_r;
  logic sync_write;
  logic async_write;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  assign wr_act = !cs_n_s && !wr_n_s;
  assign rd_act = !cs_n_s && !rd_n_s;
  assign misc_mode_r = misc_r[MISC_ASYNC_MODE_BIT];
  // host timing select
  // synchronous takes the write as the strobe opens, asynchronous as it closes,
  // using address and data held from the last cycle of the strobe
  assign sync_write = !misc_mode_r && wr_act && !wr_act_d_r;
  assign async_write = misc_mode_r && !wr_act && wr_act_d_r;
  assign wr_en = sync_write || async_write;
  assign wr_addr = misc_mode_r ? hold_addr_r : addr_s;
  assign wr_data = misc_mode_r ? hold_data_r : wdata_s;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wr_act_d_r <= 1'b0;
      hold_addr_r <= 8'h00;
      hold_data_r <= 8'h00;
    end else begin
      wr_act_d_r <= wr_act;
      if (wr_act) begin
        hold_addr_r <= addr_s;
        hold_data_r <= wdata_s;
      end
    end
  end

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic wr_restart;
  logic wr_enable;
  logic wr_cont;
  logic wr_misc;
  logic wr_rate;
  logic wr_rcc;
  logic wr_loop;
  logic wr_intv;

  assign wr_restart = wr_en && (wr_addr == OFF_TIMER_RESTART);
  assign wr_enable = wr_en && (wr_addr == OFF_TIMER_ENABLE);
  assign wr_cont = wr_en && (wr_addr == OFF_TIMER_CONTINUOUS);
  assign wr_misc = wr_en && (wr_addr == OFF_MISC_MODE_CONTROL);
  assign wr_rate = wr_en && (wr_addr == OFF_RATE_SELECT_LOW);
  assign wr_rcc = wr_en && (wr_addr == OFF_RECEIVE_CONVERTER_CONTROL);
  assign wr_loop = wr_en && (wr_addr == OFF_LOOP_MODES);
  assign wr_intv = wr_en && is_interval(wr_addr);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] restart_r;
  logic [7:0] restart_nxt;
  logic [7:0] enable_r;
  logic [7:0] cont_r;
  logic [7:0] rate_low_r;
  logic [7:0] rcc_r;
  logic [7:0] loop_r;
  logic [NUM_TIMERS-1:0] reload_ack;

  // restart self-clear
  // a host write in the same cycle as the reload wins, so a fresh request is kept
  assign restart_nxt = wr_restart ? wr_data : (restart_r & ~reload_ack);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      restart_r <= RST_TIMER_BITS;
      enable_r <= RST_TIMER_BITS;
      cont_r <= RST_TIMER_BITS;
      misc_r <= RST_MISC_MODE_CONTROL;
      rate_low_r <= RST_RATE_SELECT_LOW;
      loop_r <= RST_LOOP_MODES;
      rcc_r <= RST_RECEIVE_CONVERTER_CONTROL;
    end else begin
      restart_r <= restart_nxt;
      if (wr_enable) begin
        enable_r <= wr_data;
      end
      if (wr_cont) begin
        cont_r <= wr_data;
      end
      if (wr_misc) begin
        misc_r <= wr_data;
      end
      if (wr_rate) begin
        rate_low_r <= wr_data;
      end
      if (wr_loop) begin
        loop_r <= wr_data;
      end
      if (wr_rcc) begin
        rcc_r <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // interval registers
  // ----------------------------------------
  logic [15:0] interval_r [NUM_TIMERS];
  logic [15:0] timer_count [NUM_TIMERS];
  logic [2:0] wr_idx;

  assign wr_idx = wr_addr[3:1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_intv
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          interval_r[gi] <= RST_INTERVAL;
        end else if (wr_intv && (wr_idx == 3'(gi))) begin
          if (wr_addr[0]) begin
            interval_r[gi][15:8] <= wr_data;
          end else begin
            interval_r[gi][7:0] <= wr_data;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // symbol and startup step ticks
  // ----------------------------------------
  logic [3:0] mclk_div_r;
  logic [9:0] step_div_r;
  logic regen_clock;
  logic sym_tick;
  logic step_tick;

  assign regen_clock = misc_r[MISC_REGEN_CLOCK_BIT];
  // regenerator symbol clock
  // bypass ignores the synthesizer strobe and divides the master clock by sixteen
  assign sym_tick = regen_clock ? (mclk_div_r == SYMBOL_DIV_LAST) : SYNTH_SYMBOL_TICK;
  assign step_tick = sym_tick && (step_div_r == STARTUP_DIV_LAST);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      mclk_div_r <= 4'h0;
      step_div_r <= 10'h000;
    end else begin
      mclk_div_r <= regen_clock ? mclk_div_r + 4'h1 : 4'h0;
      if (sym_tick) begin
        step_div_r <= step_div_r + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [NUM_TIMERS-1:0] zero_nxt;

  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
      logic timer_tick;
      assign timer_tick = (gi < NUM_STARTUP_TIMERS) ? step_tick : sym_tick;
      countdown_timer u_timer (
        .clock(CLOCK),
        .resetn(RESETN),
        .tick(timer_tick),
        .interval(interval_r[gi]),
        .restart(restart_r[gi]),
        .enable(enable_r[gi]),
        .continuous(cont_r[gi]),
        .reload_ack(reload_ack[gi]),
        .count_r(timer_count[gi])
      );
      assign zero_nxt[gi] = (timer_count[gi] == 16'h0000);
    end
  endgenerate

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rd_data;
  logic [15:0] rd_intv;

  assign rd_intv = interval_r[addr_s[3:1]];
  assign rd_data = is_interval(addr_s) ? (addr_s[0] ? rd_intv[15:8] : rd_intv[7:0]) :
                   (addr_s == OFF_TIMER_RESTART) ? restart_r :
                   (addr_s == OFF_TIMER_ENABLE) ? enable_r :
                   (addr_s == OFF_TIMER_CONTINUOUS) ? cont_r :
                   (addr_s == OFF_MISC_MODE_CONTROL) ? misc_r :
                   (addr_s == OFF_RATE_SELECT_LOW) ? rate_low_r :
                   (addr_s == OFF_RECEIVE_CONVERTER_CONTROL) ? rcc_r :
                   (addr_s == OFF_LOOP_MODES) ? loop_r : 8'h00;

  // ----------------------------------------
  // analog and synthesizer controls
  // ----------------------------------------
  logic [9:0] rate_code;
  logic [9:0] rate_nxt;
  logic [1:0] loopback;
  logic rx_main_dis_nxt;
  logic bal_dis_nxt;
  logic tx_dis_nxt;
  logic int_loop_nxt;

  assign rate_code = {loop_r[LOOP_MODES_RATE_HIGH_LSB +: 2], rate_low_r};
  // zero means 1280 kbps
  // out-of-range codes from software pass through unchanged; the synthesizer owns them
  assign rate_nxt = (rate_code == RATE_CODE_UNPROGRAMMED) ? RATE_CODE_DEFAULT : rate_code;
  assign loopback = rcc_r[RCC_LOOPBACK_LSB +: 2];
  assign rx_main_dis_nxt = (loopback == LOOPBACK_TRANSMITTING);
  assign bal_dis_nxt = (loopback == LOOPBACK_NO_BALANCE);
  assign tx_dis_nxt = (loopback == LOOPBACK_SILENT);
  assign int_loop_nxt = (loopback == LOOPBACK_SILENT);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      HOST_DATA_OUT <= 8'h00;
      HOST_DATA_OE <= 1'b0;
      RATE_SELECT <= RATE_CODE_DEFAULT;
      SYNTH_BYPASS <= 1'b0;
      HOST_ASYNC_TIMING <= 1'b0;
      SYMBOL_STROBE <= 1'b0;
      TIMER_AT_ZERO <= {NUM_TIMERS{1'b1}};
      FILTER_RANGE <= 2'h0;
      PULSE_POLE <= 1'b0;
      VGA_GAIN <= 3'h0;
      RX_MAIN_DISABLE <= 1'b0;
      BALANCE_DISABLE <= 1'b0;
      TX_DISABLE <= 1'b0;
      INTERNAL_LOOP <= 1'b0;
    end else begin
      HOST_DATA_OUT <= rd_act ? rd_data : 8'h00;
      HOST_DATA_OE <= rd_act;
      RATE_SELECT <= rate_nxt;
      SYNTH_BYPASS <= regen_clock;
      HOST_ASYNC_TIMING <= misc_mode_r;
      SYMBOL_STROBE <= sym_tick;
      TIMER_AT_ZERO <= zero_nxt;
      FILTER_RANGE <= rcc_r[RCC_FILTER_LSB +: 2];
      PULSE_POLE <= rcc_r[RCC_PULSE_POLE_BIT];
      VGA_GAIN <= rcc_r[RCC_GAIN_LSB +: 3];
      RX_MAIN_DISABLE <= rx_main_dis_nxt;
      BALANCE_DISABLE <= bal_dis_nxt;
      TX_DISABLE <= tx_dis_nxt;
      INTERNAL_LOOP <= int_loop_nxt;
    end
  end

endmodule
`default_nettype wire

// ### tb/xcvr_cfg_regs_assertions.sv
// assertion checker for the transceiver configuration register bank
// assumes it is bound to the bank's top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module xcvr_cfg_regs_assertions
  import xcvr_cfg_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic HOST_CS_N,
  input wire logic HOST_RD_N,
  input wire logic HOST_DATA_OE,
  input wire logic [9:0] RATE_SELECT,
  input wire logic SYNTH_BYPASS,
  input wire logic HOST_ASYNC_TIMING,
  input wire logic SYMBOL_STROBE,
  input wire logic [NUM_TIMERS-1:0] TIMER_AT_ZERO,
  input wire logic RX_MAIN_DISABLE,
  input wire logic BALANCE_DISABLE,
  input wire logic TX_DISABLE,
  input wire logic INTERNAL_LOOP
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  wire rd_act = !HOST_CS_N && !HOST_RD_N;
  logic [5:0] run_r;
  logic [5:0] gap_r;
  // run length guards the bypass switch-over, where one odd gap is legal
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      run_r <= 6'h00;
      gap_r <= 6'h00;
    end else begin
      run_r <= !SYNTH_BYPASS ? 6'h00 : (run_r == 6'h3f ? run_r : run_r + 6'h01);
      gap_r <= SYMBOL_STROBE ? 6'h00 : (gap_r == 6'h3f ? gap_r : gap_r + 6'h01);
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence read_begin;
    $rose(rd_act) ##1 rd_act [*2];
  endsequence
  sequence read_end;
    $fell(rd_act);
  endsequence

  reset_vals_a: assert property ($rose(RESETN) |-> !HOST_DATA_OE && !SYNTH_BYPASS &&
    !HOST_ASYNC_TIMING && RATE_SELECT == RATE_CODE_DEFAULT && TIMER_AT_ZERO == 8'hff)
    else $error("outputs wrong after reset");
  rate_default_a: assert property (RATE_SELECT != RATE_CODE_UNPROGRAMMED)
    else $error("rate code zero reached synthesizer");
  regen_period_a: assert property (SYNTH_BYPASS && run_r > 6'h14 |->
    gap_r <= 6'h0f && (!SYMBOL_STROBE || gap_r == 6'h0f))
    else $error("bypass symbol period not sixteen clocks");
  loop_onehot_a: assert property ($onehot0({RX_MAIN_DISABLE, BALANCE_DISABLE, TX_DISABLE}))
    else $error("more than one loopback mode active");
  silent_pair_a: assert property (TX_DISABLE == INTERNAL_LOOP)
    else $error("silent loopback outputs disagree");
  read_answer_a: assert property (read_begin |-> !HOST_DATA_OE ##1 HOST_DATA_OE)
    else $error("read data enable lag wrong");
  read_release_a: assert property (read_end |-> HOST_DATA_OE [*3] ##1 !HOST_DATA_OE)
    else $error("read data enable release lag wrong");
  timer_tick_a: assert property ($changed(TIMER_AT_ZERO) |-> $past(SYMBOL_STROBE))
    else $error("timer moved without a symbol tick");
endmodule

bind xcvr_cfg_regs xcvr_cfg_regs_assertions u_xcvr_cfg_regs_assertions (
  .CLOCK(CLOCK),
  .RESETN(RESETN),
  .HOST_CS_N(HOST_CS_N),
  .HOST_RD_N(HOST_RD_N),
  .HOST_DATA_OE(HOST_DATA_OE),
  .RATE_SELECT(RATE_SELECT),
  .SYNTH_BYPASS(SYNTH_BYPASS),
  .HOST_ASYNC_TIMING(HOST_ASYNC_TIMING),
  .SYMBOL_STROBE(SYMBOL_STROBE),
  .TIMER_AT_ZERO(TIMER_AT_ZERO),
  .RX_MAIN_DISABLE(RX_MAIN_DISABLE),
  .BALANCE_DISABLE(BALANCE_DISABLE),
  .TX_DISABLE(TX_DISABLE),
  .INTERNAL_LOOP(INTERNAL_LOOP)
);
`default_nettype wire

// ### tb/transceiver_timer_rate_config_regs_test.sv
// self-checking bench for the transceiver configuration register bank
// assumes host pins pass two sync flops; write strobes are held 4 cycles and read strobes 5
`timescale 1ns/1ps
`default_nettype none
module transceiver_timer_rate_config_regs_test
  import xcvr_cfg_pkg::*;
;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic HOST_CS_N = 1'b1;
  logic HOST_RD_N = 1'b1;
  logic HOST_WR_N = 1'b1;
  logic [7:0] HOST_ADDR = 8'h00;
  logic [7:0] HOST_DATA_IN = 8'h00;
  logic SYNTH_SYMBOL_TICK = 1'b0;
  logic [7:0] HOST_DATA_OUT;
  logic HOST_DATA_OE;
  logic [9:0] RATE_SELECT;
  logic SYNTH_BYPASS;
  logic HOST_ASYNC_TIMING;
  logic SYMBOL_STROBE;
  logic [7:0] TIMER_AT_ZERO;
  logic [1:0] FILTER_RANGE;
  logic PULSE_POLE;
  logic [2:0] VGA_GAIN;
  logic RX_MAIN_DISABLE;
  logic BALANCE_DISABLE;
  logic TX_DISABLE;
  logic INTERNAL_LOOP;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] mem [8'h0f:8'h21];

  xcvr_cfg_regs u_xcvr_cfg_regs (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .HOST_CS_N(HOST_CS_N),
    .HOST_RD_N(HOST_RD_N),
    .HOST_WR_N(HOST_WR_N),
    .HOST_ADDR(HOST_ADDR),
    .HOST_DATA_IN(HOST_DATA_IN),
    .HOST_DATA_OUT(HOST_DATA_OUT),
    .HOST_DATA_OE(HOST_DATA_OE),
    .SYNTH_SYMBOL_TICK(SYNTH_SYMBOL_TICK),
    .RATE_SELECT(RATE_SELECT),
    .SYNTH_BYPASS(SYNTH_BYPASS),
    .HOST_ASYNC_TIMING(HOST_ASYNC_TIMING),
    .SYMBOL_STROBE(SYMBOL_STROBE),
    .TIMER_AT_ZERO(TIMER_AT_ZERO),
    .FILTER_RANGE(FILTER_RANGE),
    .PULSE_POLE(PULSE_POLE),
    .VGA_GAIN(VGA_GAIN),
    .RX_MAIN_DISABLE(RX_MAIN_DISABLE),
    .BALANCE_DISABLE(BALANCE_DISABLE),
    .TX_DISABLE(TX_DISABLE),
    .INTERNAL_LOOP(INTERNAL_LOOP)
  );

  // ----------------------------------------
  // clock, symbol ticks, hang guard
  // ----------------------------------------
  always #2 CLOCK = ~CLOCK;
  // one symbol every second clock keeps timer runs short
  always @(negedge CLOCK) SYNTH_SYMBOL_TICK <= ~SYNTH_SYMBOL_TICK;
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address settles two cycles before the strobe
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    HOST_ADDR = a;
    HOST_DATA_IN = d;
    repeat (2) @(negedge CLOCK);
    HOST_CS_N = 1'b0;
    HOST_WR_N = 1'b0;
    repeat (4) @(negedge CLOCK);
    HOST_CS_N = 1'b1;
    HOST_WR_N = 1'b1;
    repeat (4) @(negedge CLOCK);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    HOST_ADDR = a;
    repeat (2) @(negedge CLOCK);
    HOST_CS_N = 1'b0;
    HOST_RD_N = 1'b0;
    repeat (5) @(negedge CLOCK);
    chk($sformatf("reg %h", a), 16'(exp), 16'(HOST_DATA_OUT));
    chk("data enable", 16'h0001, 16'(HOST_DATA_OE));
    HOST_CS_N = 1'b1;
    HOST_RD_N = 1'b1;
    repeat (4) @(negedge CLOCK);
  endtask

  // symbols counted from one rise of a zero flag to the next
  task automatic span(input int b, output int n);
    int k;
    bit seen0;
    n = 0;
    seen0 = 1'b0;
    for (k = 0; k < 20000 && !(seen0 && TIMER_AT_ZERO[b] === 1'b1); k++) begin
      @(negedge CLOCK);
      n += int'(SYMBOL_STROBE);
      if (TIMER_AT_ZERO[b] === 1'b0) seen0 = 1'b1;
    end
  endtask

  function automatic logic [3:0] loop_exp(input logic [1:0] m);
    return {m == LOOPBACK_TRANSMITTING, m == LOOPBACK_NO_BALANCE, m == LOOPBACK_SILENT, m == LOOPBACK_SILENT};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [9:0] r;
    int n;
    int k;
    void'($urandom(32'hc72da048));
    repeat (4) @(negedge CLOCK);
    RESETN = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk("rate", 16'h00a0, 16'(RATE_SELECT));
    rchk(OFF_MISC_MODE_CONTROL, 8'h00);
    rchk(OFF_RATE_SELECT_LOW, 8'h00);
    $display("reset done");
    for (k = 8'h0f; k <= 8'h21; k++) begin
      mem[k] = 8'($urandom);
      if (k == 8'h0f) mem[k] = mem[k] & 8'hde;
      hw(8'(k), mem[k]);
    end
    hw(8'h30, 8'h5a);
    for (k = 8'h0f; k <= 8'h21; k++) rchk(8'(k), mem[k]);
    rchk(8'h30, 8'h00);
    RESETN = 1'b0;
    repeat (4) @(negedge CLOCK);
    RESETN = 1'b1;
    repeat (3) @(negedge CLOCK);
    rchk(OFF_MISC_MODE_CONTROL, 8'h00);
    $display("readback done");
    for (k = 0; k < 16; k++) begin
      d = {4'(k), 4'($urandom)};
      hw(OFF_RECEIVE_CONVERTER_CONTROL, d);
      chk("filter", 16'(d[7:6]), 16'(FILTER_RANGE));
      chk("pole gain", 16'(d[3:0]), 16'({PULSE_POLE, VGA_GAIN}));
      chk("loopback", 16'(loop_exp(d[5:4])),
          16'({RX_MAIN_DISABLE, BALANCE_DISABLE, TX_DISABLE, INTERNAL_LOOP}));
    end
    $display("converter done");
    for (k = 0; k < 4; k++) begin
      r = (k == 0) ? 10'h012 : (k == 1) ? 10'h122 : 10'(18 + $urandom % 273);
      hw(OFF_RATE_SELECT_LOW, r[7:0]);
      hw(OFF_LOOP_MODES, {r[9:8], 6'h00});
      chk("rate", 16'(r), 16'(RATE_SELECT));
    end
    hw(OFF_RATE_SELECT_LOW, 8'h00);
    hw(OFF_LOOP_MODES, 8'h00);
    chk("rate", 16'h00a0, 16'(RATE_SELECT));
    hw(OFF_MISC_MODE_CONTROL, 8'h01);
    chk("async", 16'h0001, 16'(HOST_ASYNC_TIMING));
    d = 8'($urandom);
    hw(OFF_GENERAL_INTERVAL_FOUR, d);
    rchk(OFF_GENERAL_INTERVAL_FOUR, d);
    hw(OFF_MISC_MODE_CONTROL, 8'h00);
    chk("async", 16'h0000, 16'(HOST_ASYNC_TIMING));
    $display("rate and host done");
    hw(OFF_MISC_MODE_CONTROL, 8'h20);
    repeat (40) @(negedge CLOCK);
    n = 0;
    repeat (160) begin
      @(negedge CLOCK);
      n += int'(SYMBOL_STROBE);
    end
    chk("regen strobes", 16'h000a, 16'(n));
    chk("bypass", 16'h0001, 16'(SYNTH_BYPASS));
    hw(OFF_MISC_MODE_CONTROL, 8'h00);
    $display("regenerator done");
    d = 8'($urandom % 16);
    hw(OFF_METER_INTERVAL, d);
    hw(OFF_METER_INTERVAL + 8'h01, 8'h01);
    hw(OFF_STARTUP_INTERVAL_ONE, 8'h01);
    hw(OFF_TIMER_CONTINUOUS, 8'h11);
    hw(OFF_TIMER_ENABLE, 8'h11);
    hw(OFF_TIMER_RESTART, 8'h11);
    span(4, n);
    span(4, n);
    chk("meter period", 16'h0101 + 16'(d), 16'(n));
    span(0, n);
    span(0, n);
    chk("startup period", 16'h0800, 16'(n));
    rchk(OFF_TIMER_RESTART, 8'h00);
    // one-shot general timer: restart loads while disabled, then runs down and stays at zero
    d = 8'h08 + 8'($urandom % 8);
    hw(OFF_GENERAL_INTERVAL_THREE, d);
    hw(OFF_TIMER_RESTART, 8'h40);
    chk("restart load", 16'h0000, 16'(TIMER_AT_ZERO[6]));
    hw(OFF_TIMER_ENABLE, 8'h40);
    chk("symbol count", 16'h0000, 16'(TIMER_AT_ZERO[6]));
    repeat (40) @(negedge CLOCK);
    chk("single run", 16'h0001, 16'(TIMER_AT_ZERO[6]));
    $display("timers done");
    wrap_up();
  end
endmodule
`default_nettype wire
